/* File: rtl/core_data_space.sv */
// Core stack pointer, status flags and data-space access block.
`timescale 1ns/100ps
`include "core_ds_consts.svh"
// Function
// - stack pointer is high byte over low
// - pointer bytes at 0x3D/0x3E, reset last SRAM
// - I/O address equals data offset, no 0x20 shift
// - status at 0x3F / I/O 0x3F, reset zero
// - no interrupt while global enable clear
// - interrupt clears enable, return sets it
// - set/clear interrupt ops drive enable
// - bit store/load use copy flag
// - sign flag equals negative xor overflow
// - half carry and overflow flags recorded
// - negative, zero and carry flags recorded
// - flash is 512 words, 9-bit counter
// - flash mapped from data address 0x4000
// - 64 I/O then 32 SRAM locations
// - lock and flash windows are read-only
// - pointer pairs pre-decrement or post-increment
// - direct access limited to 0x40..0xBF
// - SRAM access takes two cycles
// - bit ops on I/O 0x00..0x1F, not serial
// - bit set/clear writes only that bit
// - stack moves by one or two
module core_data_space
	import core_ds_pkg::*;
#(
	parameter int SERIAL_FIRST = 6'h18,
	parameter int SERIAL_LAST  = 6'h1B
)(
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	input  wire logic        i_req,
	input  wire logic        i_we,
	input  wire logic        i_is_io_op,
	input  wire logic        i_is_direct,
	input  wire logic [15:0] i_addr,
	input  wire logic  [7:0] i_wdata,
	input  wire logic  [7:0] i_io_rdata,
	input  wire logic [15:0] i_flash_rdata,
	input  wire logic  [7:0] i_lock_rdata,
	input  wire bit_op_t     i_bit_op,
	input  wire logic  [5:0] i_bit_addr,
	input  wire logic  [2:0] i_bit_sel,
	input  wire sp_op_t      i_sp_op,
	input  wire logic        i_irq_pending,
	input  wire logic        i_irq_taken,
	input  wire logic        i_return_from_interrupt_op,
	input  wire logic        i_sei,
	input  wire logic        i_cli,
	input  wire logic        i_bst,
	input  wire logic        i_bst_val,
	input  wire logic        i_bld,
	input  wire logic        i_alu_upd,
	input  wire logic  [5:0] i_alu_mask,
	input  wire logic  [5:0] i_alu_flags,
	input  wire ptr_mode_t   i_ptr_mode,
	input  wire logic [15:0] i_ptr_in,
	input  wire logic  [8:0] i_pc,
	output logic      [15:0] o_stack_pointer,
	output logic       [7:0] o_status,
	output logic             o_irq_accept,
	output logic             o_bld_bit,
	output logic      [15:0] o_ptr_out,
	output logic      [15:0] o_ptr_addr,
	output logic       [7:0] o_rdata,
	output logic             o_rvalid,
	output logic             o_busy,
	output logic             o_io_we,
	output logic       [5:0] o_io_addr,
	output logic       [7:0] o_io_wdata,
	output logic       [7:0] o_io_wmask,
	output logic             o_skip,
	output logic             o_fault,
	output logic       [8:0] o_flash_addr
);

	// ------------------------------------------------------------------
	// Local state
	// ------------------------------------------------------------------
	logic  [7:0] stack_pointer_low;
	logic  [7:0] stack_pointer_high;
	logic  [7:0] cpu_status_flags;
	logic  [7:0] sram [0:`SRAM_SIZE-1];
	logic        sram_phase;
	logic        flash_phase;
	logic        flash_high_q;
	logic  [4:0] sram_idx_q;
	logic        sram_we_q;
	logic  [7:0] sram_wdata_q;
	logic [15:0] data_addr;
	logic [15:0] eff_addr;
	region_t     region;
	logic  [5:0] dec_io;
	logic  [4:0] dec_sram;
	logic  [8:0] dec_word;
	logic        dec_high;
	logic        direct_bad;
	logic        acc;
	logic        bit_ok;
	logic  [7:0] bit_mask;
	logic [15:0] sp_full;

	function automatic logic [7:0] onehot(input logic [2:0] sel);
		onehot = 8'h01 << sel;
	endfunction

	function automatic logic is_reg(input logic [5:0] a,
		input logic [5:0] which);
		is_reg = (a == which);
	endfunction

	// ------------------------------------------------------------------
	// Address formation
	// ------------------------------------------------------------------
	// I/O op offset used unchanged as data address.
	assign data_addr = i_is_io_op ? ({10'h000, i_addr[5:0]})
		: i_addr;
	assign eff_addr = (i_ptr_mode == PTR_PREDEC) ?
		i_ptr_in - 16'h0001 : data_addr;

	data_space_decode u_decode (
		.i_addr       (i_is_io_op ? data_addr : eff_addr),
		.o_region     (region),
		.o_io_addr    (dec_io),
		.o_sram_idx   (dec_sram),
		.o_flash_word (dec_word),
		.o_flash_high (dec_high)
	);

	assign direct_bad = i_is_direct && !i_is_io_op &&
		(i_addr < `DIRECT_LO || i_addr > `DIRECT_HI);
	assign acc = i_req && !o_busy && !direct_bad;
	assign sp_full = {stack_pointer_high, stack_pointer_low};
	// bit ops only low I/O, serial excluded.
	assign bit_ok = i_bit_addr <= `BIT_IO_LAST &&
		!(i_bit_addr >= 6'(SERIAL_FIRST) &&
		i_bit_addr <= 6'(SERIAL_LAST));
	assign bit_mask = onehot(i_bit_sel);

	// ------------------------------------------------------------------
	// Stack pointer
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			stack_pointer_low  <= 8'(`LAST_SRAM_ADDR);
			stack_pointer_high <= 8'(`LAST_SRAM_ADDR >> 8);
		end else if (i_sp_op != SP_NONE) begin
			// push/pop by one, call/return by two.
			unique case (i_sp_op)
				SP_PUSH: {stack_pointer_high, stack_pointer_low} <=
					sp_full - 16'h0001;
				SP_POP:  {stack_pointer_high, stack_pointer_low} <=
					sp_full + 16'h0001;
				SP_CALL: {stack_pointer_high, stack_pointer_low} <=
					sp_full - 16'h0002;
				SP_RET:  {stack_pointer_high, stack_pointer_low} <=
					sp_full + 16'h0002;
				default: ;
			endcase
		end else if (acc && i_we && region == REGION_IO) begin
			if (is_reg(dec_io, `SP_LOW_IO))
				stack_pointer_low <= i_wdata;
			if (is_reg(dec_io, `SP_HIGH_IO))
				stack_pointer_high <= i_wdata;
		end
	end

	// ------------------------------------------------------------------
	// Status flags
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cpu_status_flags <= `STATUS_RESET;
		end else begin
			if (acc && i_we && region == REGION_IO &&
				is_reg(dec_io, `STATUS_IO))
				cpu_status_flags <= i_wdata;
			if (i_alu_upd) begin
				if (i_alu_mask[5])
					cpu_status_flags[`ST_H] <= i_alu_flags[5];
				if (i_alu_mask[3])
					cpu_status_flags[`ST_V] <= i_alu_flags[3];
				if (i_alu_mask[2])
					cpu_status_flags[`ST_N] <= i_alu_flags[2];
				if (i_alu_mask[1])
					cpu_status_flags[`ST_Z] <= i_alu_flags[1];
				if (i_alu_mask[0])
					cpu_status_flags[`ST_C] <= i_alu_flags[0];
				cpu_status_flags[`ST_S] <=
					(i_alu_mask[2] ? i_alu_flags[2] :
					cpu_status_flags[`ST_N]) ^
					(i_alu_mask[3] ? i_alu_flags[3] :
					cpu_status_flags[`ST_V]);
			end
			if (i_bst)
				cpu_status_flags[`ST_T] <= i_bst_val;
			if (i_sei)
				cpu_status_flags[`ST_I] <= 1'b1;
			if (i_cli)
				cpu_status_flags[`ST_I] <= 1'b0;
			if (i_return_from_interrupt_op)
				cpu_status_flags[`ST_I] <= 1'b1;
			if (i_irq_taken)
				cpu_status_flags[`ST_I] <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq_accept <= 1'b0;
			o_bld_bit    <= 1'b0;
			o_stack_pointer <= 16'h0000;
			o_status     <= 8'h00;
		end else begin
			o_irq_accept <= i_irq_pending &&
				cpu_status_flags[`ST_I] && !i_cli;
			// copy flag out for bit load.
			o_bld_bit    <= i_bld ? cpu_status_flags[`ST_T] :
				o_bld_bit;
			o_stack_pointer <= sp_full;
			o_status     <= cpu_status_flags;
		end
	end

	// ------------------------------------------------------------------
	// Pointer update
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_ptr_out  <= 16'h0000;
			o_ptr_addr <= 16'h0000;
		end else if (acc) begin
			o_ptr_addr <= eff_addr;
			unique case (i_ptr_mode)
				PTR_PREDEC:  o_ptr_out <= eff_addr;
				PTR_POSTINC: o_ptr_out <= i_ptr_in + 16'h0001;
				default:     o_ptr_out <= i_ptr_in;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Data access
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sram_phase   <= 1'b0;
			flash_phase  <= 1'b0;
			flash_high_q <= 1'b0;
			sram_idx_q   <= 5'h00;
			sram_we_q    <= 1'b0;
			sram_wdata_q <= 8'h00;
			o_busy       <= 1'b0;
		end else if (sram_phase || flash_phase) begin
			sram_phase  <= 1'b0;
			flash_phase <= 1'b0;
			o_busy      <= 1'b0;
		end else if (acc && region == REGION_SRAM) begin
			sram_phase   <= 1'b1;
			o_busy       <= 1'b1;
			sram_idx_q   <= dec_sram;
			sram_we_q    <= i_we;
			sram_wdata_q <= i_wdata;
		end else if (acc && !i_we && region == REGION_FLASH) begin
			// word fetched first, byte picked next.
			flash_phase  <= 1'b1;
			flash_high_q <= dec_high;
			o_busy       <= 1'b1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (sram_phase && sram_we_q)
			sram[sram_idx_q] <= sram_wdata_q;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata      <= 8'h00;
			o_rvalid     <= 1'b0;
			o_fault      <= 1'b0;
			o_flash_addr <= 9'h000;
		end else begin
			o_rvalid <= 1'b0;
			o_fault  <= i_req && !o_busy && (direct_bad ||
				(i_we && (region == REGION_LOCK ||
				region == REGION_FLASH || region == REGION_NONE)));
			if (sram_phase) begin
				o_rdata  <= sram[sram_idx_q];
				o_rvalid <= !sram_we_q;
			end else if (flash_phase) begin
				// flash byte from word and half.
				o_rdata  <= flash_high_q ? i_flash_rdata[15:8] :
					i_flash_rdata[7:0];
				o_rvalid <= 1'b1;
			end else if (acc && !i_we) begin
				o_rvalid <= region != REGION_SRAM &&
					region != REGION_FLASH;
				unique case (region)
					REGION_IO: begin
						if (is_reg(dec_io, `SP_LOW_IO))
							o_rdata <= stack_pointer_low;
						else if (is_reg(dec_io, `SP_HIGH_IO))
							o_rdata <= stack_pointer_high;
						else if (is_reg(dec_io, `STATUS_IO))
							o_rdata <= cpu_status_flags;
						else
							o_rdata <= i_io_rdata;
					end
					REGION_FLASH: o_rdata <= o_rdata;
					REGION_LOCK: o_rdata <= i_lock_rdata;
					REGION_SRAM: o_rdata <= o_rdata;
					default:     o_rdata <= 8'h00;
				endcase
			end
			// program counter or data window picks flash word.
			o_flash_addr <= (acc && region == REGION_FLASH) ?
				dec_word : i_pc;
		end
	end

	// ------------------------------------------------------------------
	// Peripheral I/O write and bit ops
	// ------------------------------------------------------------------
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_io_we    <= 1'b0;
			o_io_addr  <= 6'h00;
			o_io_wdata <= 8'h00;
			o_io_wmask <= 8'h00;
			o_skip     <= 1'b0;
		end else begin
			o_io_we <= 1'b0;
			o_skip  <= 1'b0;
			if (i_bit_op != BIT_NONE && bit_ok) begin
				o_io_addr <= i_bit_addr;
				unique case (i_bit_op)
					// mask holds only the chosen bit.
					BIT_SET: begin
						o_io_we    <= 1'b1;
						o_io_wdata <= bit_mask;
						o_io_wmask <= bit_mask;
					end
					BIT_CLEAR: begin
						o_io_we    <= 1'b1;
						o_io_wdata <= 8'h00;
						o_io_wmask <= bit_mask;
					end
					BIT_SKIP_SET:
						o_skip <= |(i_io_rdata & bit_mask);
					BIT_SKIP_CLEAR:
						o_skip <= !(|(i_io_rdata & bit_mask));
					default: ;
				endcase
			end else if (acc && i_we && region == REGION_IO &&
				!is_reg(dec_io, `SP_LOW_IO) &&
				!is_reg(dec_io, `SP_HIGH_IO) &&
				!is_reg(dec_io, `STATUS_IO)) begin
				o_io_we    <= 1'b1;
				o_io_addr  <= dec_io;
				o_io_wdata <= i_wdata;
				o_io_wmask <= 8'hFF;
			end
		end
	end

endmodule

/* File: rtl/core_ds_consts.svh */
// Constants for the core data-space and status register block.
`ifndef CORE_DS_CONSTS_SVH
`define CORE_DS_CONSTS_SVH

// ----------------------------------------------------------------------
// Data-space map
// ----------------------------------------------------------------------
`define IO_BASE          16'h0000
`define IO_SIZE          16'h0040
`define SRAM_BASE        16'h0040
`define SRAM_SIZE        16'h0020
`define LAST_SRAM_ADDR   16'h005F
`define DIRECT_LO        16'h0040
`define DIRECT_HI        16'h00BF
`define LOCK_BASE        16'h3F00
`define FLASH_BASE       16'h4000
`define IO_DATA_OFFSET   16'h0020
`define BIT_IO_LAST      6'h1F
`define FLASH_WORDS      512
`define PC_WIDTH         9

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SP_LOW_IO        6'h3D
`define SP_HIGH_IO       6'h3E
`define STATUS_IO        6'h3F
`define STATUS_DATA      16'h005F
`define STATUS_RESET     8'h00

// ----------------------------------------------------------------------
// Status bit positions
// ----------------------------------------------------------------------
`define ST_I             7
`define ST_T             6
`define ST_H             5
`define ST_S             4
`define ST_V             3
`define ST_N             2
`define ST_Z             1
`define ST_C             0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SRAM_ACCESS_CYC  2

`endif

/* File: rtl/core_ds_pkg.sv */
// Types for the core data-space and status register block.
package core_ds_pkg;

	typedef enum logic [2:0] {
		SP_NONE,
		SP_PUSH,
		SP_POP,
		SP_CALL,
		SP_RET
	} sp_op_t;

	typedef enum logic [1:0] {
		PTR_HOLD,
		PTR_PREDEC,
		PTR_POSTINC
	} ptr_mode_t;

	typedef enum logic [2:0] {
		REGION_IO,
		REGION_SRAM,
		REGION_LOCK,
		REGION_FLASH,
		REGION_NONE
	} region_t;

	typedef enum logic [2:0] {
		BIT_NONE,
		BIT_SET,
		BIT_CLEAR,
		BIT_SKIP_SET,
		BIT_SKIP_CLEAR
	} bit_op_t;

endpackage

/* File: rtl/data_space_decode.sv */
// Combinational decode of a data-space address into its region.
`timescale 1ns/100ps
`include "core_ds_consts.svh"
module data_space_decode
	import core_ds_pkg::*;
(
	input  wire logic [15:0] i_addr,
	output region_t          o_region,
	output logic       [5:0] o_io_addr,
	output logic       [4:0] o_sram_idx,
	output logic       [8:0] o_flash_word,
	output logic             o_flash_high
);

	logic [15:0] flash_off;

	assign flash_off    = i_addr - `FLASH_BASE;
	assign o_flash_word = flash_off[9:1];
	assign o_flash_high = flash_off[0];
	assign o_io_addr    = i_addr[5:0];
	assign o_sram_idx   = 5'(i_addr - `SRAM_BASE);

	// I/O first, then SRAM, then NVM windows.
	always_comb begin
		if (i_addr < `IO_SIZE)
			o_region = REGION_IO;
		else if (i_addr < `SRAM_BASE + `SRAM_SIZE)
			o_region = REGION_SRAM;
		else if (i_addr >= `FLASH_BASE &&
			flash_off < 16'(2 * `FLASH_WORDS))
			o_region = REGION_FLASH;
		else if (i_addr >= `LOCK_BASE && i_addr < `FLASH_BASE)
			o_region = REGION_LOCK;
		else
			o_region = REGION_NONE;
	end

endmodule

/* File: verif/core_ds_far_model.sv */
// Behavioural read sources on the far side of the data-space block.
`timescale 1ns/100ps
module core_ds_far_model (
	input  wire logic [15:0] i_addr,
	input  wire logic  [8:0] i_flash_addr,
	output logic       [7:0] o_io_rdata,
	output logic      [15:0] o_flash_rdata,
	output logic       [7:0] o_lock_rdata
);
	// ------------------------------------------------------------
	// Read sources
	// ------------------------------------------------------------
	// word per address
	assign o_flash_rdata = {i_flash_addr[7:0] ^ 8'h5A, 7'h00, i_flash_addr[8]};
	assign o_io_rdata = {2'b01, i_addr[5:0]};
	assign o_lock_rdata = 8'hC3;
endmodule

/* File: verif/core_ds_checker.sv */
// Assertion checker for the core data-space block.
`timescale 1ns/100ps
module core_ds_checker
	import core_ds_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_rst_n,
	input wire logic        i_req,
	input wire logic        i_we,
	input wire logic        i_is_io_op,
	input wire logic        i_is_direct,
	input wire logic [15:0] i_addr,
	input wire sp_op_t      i_sp_op,
	input wire logic        i_irq_pending,
	input wire logic        i_irq_taken,
	input wire logic        i_return_from_interrupt_op,
	input wire logic        i_sei,
	input wire logic        i_cli,
	input wire logic        i_bst,
	input wire logic        i_bst_val,
	input wire logic        i_alu_upd,
	input wire logic [15:0] o_stack_pointer,
	input wire logic  [7:0] o_status,
	input wire logic        o_irq_accept,
	input wire logic        o_rvalid,
	input wire logic        o_busy,
	input wire logic        o_fault
);
	default clocking @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	logic sram_rd;
	assign sram_rd = i_req && !i_we && !i_is_io_op && !i_is_direct && !o_busy
		&& i_addr inside {[16'h0040:16'h005F]};
	sequence s_sram_answer;
		o_busy ##1 (o_rvalid && !o_busy);
	endsequence
	sequence s_bad_direct;
		i_req && i_is_direct && !o_busy
		&& !(i_addr inside {[16'h0040:16'h00BF]});
	endsequence
	a_sram_read: assert property (
		sram_rd |=> s_sram_answer) else $error("sram read timing");
	a_direct_range: assert property (
		s_bad_direct |-> ##[1:2] o_fault) else $error("direct range");
	a_irq_gate: assert property (
		o_irq_accept |-> $past(i_irq_pending) && !$past(i_cli))
		else $error("irq accept gate");
	a_irq_entry: assert property (
		i_irq_taken |=> ##1 !o_status[7]) else $error("irq entry");
	a_return_from_interrupt_op_set: assert property (
		i_return_from_interrupt_op && !i_irq_taken |=> ##1 o_status[7]) else $error("return");
	a_enable_ops: assert property (
		(i_sei || i_cli) && !i_return_from_interrupt_op && !i_irq_taken
		|=> ##1 o_status[7] != $past(i_cli, 2)) else $error("enable op");
	a_copy_flag: assert property (
		i_bst |=> ##1 o_status[6] == $past(i_bst_val, 2))
		else $error("copy flag");
	a_sign_flag: assert property (
		i_alu_upd |=> ##1 o_status[4] == (o_status[2] ^ o_status[3]))
		else $error("sign flag");
	a_stack_push: assert property (
		i_sp_op == SP_PUSH |=> ##1 o_stack_pointer
		== $past(o_stack_pointer) - 16'h0001) else $error("push");
endmodule

bind core_data_space core_ds_checker chk_u (
	.i_mclk, .i_rst_n, .i_req, .i_we, .i_is_io_op, .i_is_direct, .i_addr,
	.i_sp_op, .i_irq_pending, .i_irq_taken, .i_return_from_interrupt_op, .i_sei, .i_cli,
	.i_bst, .i_bst_val, .i_alu_upd, .o_stack_pointer, .o_status,
	.o_irq_accept, .o_rvalid, .o_busy, .o_fault);

/* File: verif/core_data_space_and_status_tb.sv */
// Self-checking bench for the core data-space and status block.
`timescale 1ns/100ps
module core_data_space_and_status_tb
	import core_ds_pkg::*;
;
	logic        i_mclk = 0, i_rst_n = 0, i_req = 0, i_we = 0;
	logic        i_is_io_op = 0, i_is_direct = 0, i_irq_pending = 0;
	logic        i_irq_taken = 0, i_return_from_interrupt_op = 0, i_sei = 0, i_cli = 0;
	logic        i_bst = 0, i_bst_val = 0, i_bld = 0, i_alu_upd = 0;
	logic        o_irq_accept, o_bld_bit, o_rvalid, o_busy, o_io_we;
	logic        o_skip, o_fault, v, f, w, k, q, bz, bb;
	logic [15:0] i_addr = 0, i_ptr_in = 0, i_flash_rdata, o_stack_pointer;
	logic [15:0] o_ptr_out, o_ptr_addr, sp, po, pa;
	logic [7:0]  i_wdata = 0, i_io_rdata, i_lock_rdata, o_status, o_rdata;
	logic [7:0]  o_io_wmask, o_io_wdata, d, m, st, wd;
	logic [5:0]  i_bit_addr = 0, i_alu_mask = 0, i_alu_flags = 0;
	logic [5:0]  o_io_addr, a;
	logic [2:0]  i_bit_sel = 0;
	logic [8:0]  i_pc = 0, o_flash_addr, fa;
	bit_op_t     i_bit_op = BIT_NONE;
	sp_op_t      i_sp_op = SP_NONE;
	ptr_mode_t   i_ptr_mode = PTR_HOLD;
	int          errors = 0, checks = 0, cyc = 0;

	core_data_space dut_u (.i_mclk, .i_rst_n, .i_req, .i_we, .i_is_io_op,
		.i_is_direct, .i_addr, .i_wdata, .i_io_rdata, .i_flash_rdata,
		.i_lock_rdata, .i_bit_op, .i_bit_addr, .i_bit_sel, .i_sp_op,
		.i_irq_pending, .i_irq_taken, .i_return_from_interrupt_op, .i_sei, .i_cli, .i_bst,
		.i_bst_val, .i_bld, .i_alu_upd, .i_alu_mask, .i_alu_flags,
		.i_ptr_mode, .i_ptr_in, .i_pc, .o_stack_pointer, .o_status,
		.o_irq_accept, .o_bld_bit, .o_ptr_out, .o_ptr_addr, .o_rdata,
		.o_rvalid, .o_busy, .o_io_we, .o_io_addr, .o_io_wdata,
		.o_io_wmask, .o_skip, .o_fault, .o_flash_addr);
	core_ds_far_model far_u (.i_addr, .i_flash_addr(o_flash_addr),
		.o_io_rdata(i_io_rdata), .o_flash_rdata(i_flash_rdata),
		.o_lock_rdata(i_lock_rdata));

	always #20 i_mclk = ~i_mclk;
	always @(posedge i_mclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		if (errors == 0 && checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] e, g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task automatic fire();
		@(posedge i_mclk);
		{i_req, i_irq_pending, i_irq_taken, i_return_from_interrupt_op, i_sei} <= '0;
		{i_cli, i_bst, i_bld, i_alu_upd} <= '0;
		i_sp_op <= SP_NONE;
		i_bit_op <= BIT_NONE;
		{v, f, w, k, q, bz} = '0;
		repeat (4) begin
			#1;
			v |= o_rvalid;
			if (o_rvalid === 1'b1) d = o_rdata;
			w |= o_io_we;
			if (o_io_we === 1'b1) begin
				m = o_io_wmask;
				a = o_io_addr;
				wd = o_io_wdata;
			end
			{f, k, q, bz} = {f, k, q, bz} | {o_fault, o_skip, o_irq_accept, o_busy};
			{st, sp, po, pa, bb, fa} = {o_status, o_stack_pointer, o_ptr_out,
				o_ptr_addr, o_bld_bit, o_flash_addr};
			@(posedge i_mclk);
		end
	endtask

	task automatic acc(input logic wr, io, dr, input logic [15:0] ad,
			input logic [7:0] wd);
		{i_req, i_we, i_is_io_op, i_is_direct} <= {1'b1, wr, io, dr};
		i_addr <= ad;
		i_wdata <= wd;
		fire();
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		fire();
		chk("stack pointer", 16'h005F, sp);
		chk("status", 16'h0000, 16'(st));
		acc(0, 1, 0, 16'h003E, 8'h00);
		chk("pointer high", 16'h0000, 16'(d));
		acc(0, 1, 0, 16'h003D, 8'h00);
		chk("pointer low", 16'h005F, 16'(d));
		chk("read valid", 16'h0001, 16'(v));
	endtask

	task automatic t_stack();
		sp_op_t      ops[4] = '{SP_PUSH, SP_CALL, SP_POP, SP_RET};
		logic [15:0] spx[4] = '{16'h005E, 16'h005C, 16'h005D, 16'h005F};
		foreach (ops[j]) begin
			i_sp_op <= ops[j];
			fire();
			chk("stack pointer", spx[j], sp);
		end
		acc(1, 1, 0, 16'h003E, 8'h12);
		acc(1, 1, 0, 16'h003D, 8'h34);
		chk("joined pointer", 16'h1234, sp);
	endtask

	task automatic t_status();
		acc(1, 1, 0, 16'h003F, 8'hB5);
		acc(0, 1, 0, 16'h003F, 8'h00);
		chk("status read", 16'h00B5, 16'(d));
		{i_alu_upd, i_alu_mask, i_alu_flags} <= {1'b1, 6'h3F, 6'h08};
		fire();
		chk("overflow flags", 16'h0098, 16'(st));
		{i_alu_upd, i_alu_mask, i_alu_flags} <= {1'b1, 6'h04, 6'h04};
		fire();
		chk("negative flags", 16'h008C, 16'(st));
		{i_alu_upd, i_alu_mask, i_alu_flags} <= {1'b1, 6'h21, 6'h21};
		fire();
		chk("carry flags", 16'h00AD, 16'(st));
		{i_bst, i_bst_val} <= 2'b11;
		fire();
		chk("copy flag", 16'h00ED, 16'(st));
		i_bld <= 1;
		fire();
		chk("copy out", 16'h0001, 16'(bb));
		i_irq_pending <= 1;
		fire();
		chk("accept", 16'h0001, 16'(q));
		{i_irq_pending, i_cli} <= 2'b11;
		fire();
		chk("accept on disable", 16'h0000, 16'(q));
		chk("enable cleared", 16'h0000, 16'(st[7]));
		i_irq_pending <= 1;
		fire();
		chk("masked accept", 16'h0000, 16'(q));
		i_return_from_interrupt_op <= 1;
		fire();
		chk("enable on return", 16'h0001, 16'(st[7]));
		i_irq_taken <= 1;
		fire();
		chk("enable on entry", 16'h0000, 16'(st[7]));
		i_sei <= 1;
		fire();
		chk("enable set op", 16'h0001, 16'(st[7]));
	endtask

	task automatic t_memory();
		i_ptr_mode <= PTR_PREDEC;
		i_ptr_in <= 16'h0043;
		acc(1, 0, 0, 16'h0042, 8'h6C);
		chk("pointer down", 16'h0042, po);
		chk("pointer address", 16'h0042, pa);
		i_ptr_mode <= PTR_POSTINC;
		i_ptr_in <= 16'h0042;
		acc(0, 0, 0, 16'h0042, 8'h00);
		chk("sram data", 16'h006C, 16'(d));
		chk("sram busy", 16'h0001, 16'(bz));
		chk("pointer up", 16'h0043, po);
		i_ptr_mode <= PTR_HOLD;
		i_pc <= 9'h1A5;
		acc(0, 0, 0, 16'h4003, 8'h00);
		chk("flash high byte", 16'h005B, 16'(d));
		acc(0, 0, 0, 16'h43FE, 8'h00);
		chk("last flash word", 16'h0001, 16'(d));
		acc(1, 0, 0, 16'h4003, 8'h11);
		chk("flash write", 16'h0001, 16'(f));
		acc(1, 0, 0, 16'h3F00, 8'h11);
		chk("lock write", 16'h0001, 16'(f));
		acc(0, 0, 1, 16'h00C0, 8'h00);
		chk("direct above", 16'h0001, 16'(f));
		acc(0, 0, 1, 16'h0042, 8'h00);
		chk("direct read", 16'h006C, 16'(d));
		chk("direct fault", 16'h0000, 16'(f));
		chk("fetch address", 16'h01A5, 16'(fa));
	endtask

	task automatic t_bits();
		bit_op_t bo[4] = '{BIT_SET, BIT_CLEAR, BIT_SKIP_SET, BIT_SKIP_CLEAR};
		acc(1, 1, 0, 16'h0010, 8'hA5);
		chk("io write", 16'h0001, 16'(w));
		chk("io write mask", 16'h00FF, 16'(m));
		chk("io write data", 16'h00A5, 16'(wd));
		chk("io write target", 16'h0010, 16'(a));
		{i_bit_addr, i_bit_sel, i_addr} <= {6'h05, 3'h0, 16'h0005};
		foreach (bo[j]) begin
			i_bit_op <= bo[j];
			fire();
			chk("bit write", 16'(j < 2), 16'(w));
			chk("bit skip", 16'(j == 2), 16'(k));
			if (j < 2) chk("bit mask", 16'h0001, 16'(m));
			if (j < 2) chk("bit data", 16'(j == 0), 16'(wd));
		end
		chk("bit target", 16'h0005, 16'(a));
		i_bit_op <= BIT_SET;
		{i_bit_addr, i_addr} <= {6'h18, 16'h0018};
		fire();
		chk("serial refused", 16'h0000, 16'(w));
		i_bit_op <= BIT_SET;
		{i_bit_addr, i_addr} <= {6'h20, 16'h0020};
		fire();
		chk("high refused", 16'h0000, 16'(w));
	endtask

	initial begin
		repeat (3) @(posedge i_mclk);
		i_rst_n <= 1;
		t_reset();
		t_stack();
		t_status();
		t_memory();
		t_bits();
		end_of_test();
	end
endmodule
